// File: inc/tim_irq_pkg.sv
// constants shared by the timer interrupt device end, its cpu end and the bench
// assumes one 10 MHz system clock and a synchronous active-low reset everywhere
// Summary of operation
// RULE_01: mask bit shares position with its flag
// RULE_02: clear flag: read it, then write zero
// RULE_03: event between read and write keeps flag
// RULE_04: eleven sources, each with own mask bit
// RULE_05: two 8-bit mask registers, byte/word, reset zero
// RULE_06: level field picks request line, zero disables
// RULE_07: cpu acknowledges above mask, loads level, drives it
// RULE_08: arbitrate only when acknowledged level matches
// RULE_09: distinct nonzero ids, bits asserted serially
// RULE_10: winner drives base nibble plus source code
// RULE_11: vector stays stable while driven
// RULE_12: fixed source codes for the eleven events
// RULE_13: lowest source number wins among pending
// RULE_14: adjust field lifts one source, code zero
// RULE_15: vector base resets zero, software loads it
// RULE_16: request holds until causing flags cleared
// RULE_17: only events set flags, flags reset zero
// RULE_18: low/high flag registers, byte or word access
// RULE_19: one merged request, code picked at acknowledge
package tim_irq_pkg;
    localparam int NUM_SRC = 11;
    localparam int ARB_W = 4;
    localparam int DATA_W = 16;
    localparam int LVL_W = 3;
    localparam int VEC_W = 8;
    // device word offsets; upper byte of a word is the "low" register, lower byte the "high"
    localparam logic [1:0] OFS_MODCFG = 2'h0;
    localparam logic [1:0] OFS_IRQCFG = 2'h1;
    localparam logic [1:0] OFS_MASK = 2'h2;
    localparam logic [1:0] OFS_FLAG = 2'h3;
    localparam int MODCFG_ARB_LSB = 0;
    localparam int IRQCFG_VBA_LSB = 0;
    localparam int IRQCFG_LVL_LSB = 4;
    localparam int IRQCFG_ADJ_LSB = 8;
    localparam logic [15:0] MODCFG_RST = 16'h0000;
    localparam logic [15:0] IRQCFG_RST = 16'h0000;
    localparam logic [15:0] MASK_RST = 16'h0000;
    localparam logic [NUM_SRC-1:0] FLAG_RST = 11'h000;
    // acknowledge counter value at which the cpu end samples the vector, seven cycles after iack rises
    localparam logic [3:0] ACK_SAMPLE = 4'h6;
    // cpu end register offsets
    localparam logic [2:0] HOFS_ADDR = 3'h0;
    localparam logic [2:0] HOFS_DATA = 3'h1;
    localparam logic [2:0] HOFS_CMD = 3'h2;
    localparam logic [2:0] HOFS_IPM = 3'h3;
    localparam logic [2:0] HOFS_VEC = 3'h4;
    localparam logic [2:0] HOFS_STAT = 3'h5;
    localparam logic [2:0] HOFS_IMASK = 3'h6;
    localparam int CMD_WR = 0;
    localparam int CMD_RD = 1;
    localparam int CMD_BE_LSB = 4;
    localparam int IPM_AUTO = 3;
    localparam int ST_BUS = 0;
    localparam int ST_ACK = 1;
    localparam int ST_SPUR = 2;
    localparam int NUM_ST = 3;
endpackage

// File: inc/timer_irq_if.sv
// link between the timer interrupt device end and the cpu end on the intermodule bus
// assumes both ends run on the same clock; arbitration is a wired-or of the contenders
`timescale 1ns/100ps
interface timer_irq_if;
    logic [1:0] bus_addr;
    logic [15:0] bus_wdata;
    logic [1:0] bus_be;
    logic bus_wr;
    logic bus_rd;
    logic [15:0] bus_rdata;
    logic [7:1] irq_req;
    logic iack;
    logic [2:0] ack_level;
    logic arb_dev;
    logic arb_bus;
    logic [7:0] vec;
    logic vec_oe;
    logic [7:0] vec_bus;
    // only one contender here; further modules would be or-ed in
    assign arb_bus = arb_dev;
    assign vec_bus = vec_oe ? vec : 8'h00;
    modport dev_mp(input bus_addr, bus_wdata, bus_be, bus_wr, bus_rd, iack, ack_level, arb_bus,
        output bus_rdata, irq_req, arb_dev, vec, vec_oe);
    modport cpu_mp(output bus_addr, bus_wdata, bus_be, bus_wr, bus_rd, iack, ack_level,
        input bus_rdata, irq_req, vec_bus, vec_oe);
endinterface

// File: rtl/arb_serial.sv
// bit-serial interrupt arbitration, most significant id bit first
// assumes the bus input is the wired-or of every contender's bit in the same cycle
`timescale 1ns/100ps
module arb_serial #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // control
    input wire logic start_i,
    input wire logic join_i,
    input wire logic [W-1:0] id_i,
    input wire logic bus_i,
    // result
    output logic bit_o,
    output logic won_o
);
    logic [$clog2(W)-1:0] cnt_q;
    logic busy_q;
    logic contend_q;
    logic lost;

    // a zero of ours against a one on the bus means a higher id is present
    assign lost = busy_q && !bit_o && bus_i;

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
            contend_q <= 1'b0;
            bit_o <= 1'b0;
            won_o <= 1'b0;
        end else begin
            won_o <= 1'b0;
            if (start_i) begin
                busy_q <= 1'b1;
                contend_q <= join_i;
                cnt_q <= ($clog2(W))'(W - 1);
                bit_o <= join_i & id_i[W-1]; // RULE_09
            end else if (busy_q) begin
                if (cnt_q == '0) begin
                    busy_q <= 1'b0;
                    bit_o <= 1'b0;
                    won_o <= contend_q && !lost;
                    contend_q <= 1'b0;
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                    contend_q <= contend_q && !lost;
                    bit_o <= contend_q && !lost && id_i[cnt_q-1'b1]; // RULE_09
                end
            end
        end
    end
endmodule

// File: rtl/timer_irq_dev.sv
// timer interrupt logic: event flags, masks, request level, arbitration and vector
// assumes events are one-cycle pulses from timer datapaths on the same clock
`timescale 1ns/100ps
module timer_irq_dev (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // intermodule bus side
    timer_irq_if.dev_mp link,
    // timer datapath side
    input wire logic [tim_irq_pkg::NUM_SRC-1:0] event_i,
    output logic pending_o
);
    import tim_irq_pkg::*;

    // source k+1 sits at word bit 15-k: flags low in the upper byte, high in the lower
    function automatic logic [NUM_SRC-1:0] word_to_src(input logic [15:0] w);
        logic [NUM_SRC-1:0] s;
        s = '0;
        for (int k = 0; k < NUM_SRC; k++) begin
            s[k] = w[15-k];
        end
        return s;
    endfunction

    function automatic logic [15:0] src_to_word(input logic [NUM_SRC-1:0] s);
        logic [15:0] w;
        w = '0;
        for (int k = 0; k < NUM_SRC; k++) begin
            w[15-k] = s[k];
        end
        return w;
    endfunction

    function automatic logic [3:0] pick_code(input logic [NUM_SRC-1:0] pm, input logic [3:0] adj);
        logic [3:0] c;
        c = '0;
        for (int k = NUM_SRC - 1; k >= 0; k--) begin
            if (pm[k]) begin
                c = 4'(k + 1); // RULE_12 RULE_13
            end
        end
        if (adj != 4'h0 && adj <= 4'(NUM_SRC) && pm[adj-4'h1]) begin
            c = 4'h0; // RULE_14
        end
        return c;
    endfunction

    logic [15:0] modcfg_q;
    logic [15:0] irqcfg_q;
    logic [15:0] mask_q;
    logic [NUM_SRC-1:0] flag_q;
    logic [NUM_SRC-1:0] armed_q;
    logic [15:0] rdata_q;
    logic [7:1] irq_q;
    logic iack_prev_q;
    logic [7:0] vec_q;
    logic vec_oe_q;
    logic [15:0] bmask;
    logic [NUM_SRC-1:0] src_sel;
    logic [NUM_SRC-1:0] clr;
    logic [NUM_SRC-1:0] pm;
    logic flag_wr;
    logic flag_rd;
    logic any;
    logic [2:0] lvl;
    logic [3:0] vba;
    logic [3:0] adj;
    logic start;
    logic join_arb;
    logic arb_bit;
    logic won;

    assign bmask = {{8{link.bus_be[1]}}, {8{link.bus_be[0]}}}; // RULE_05 RULE_18
    assign src_sel = word_to_src(bmask);
    assign flag_wr = link.bus_wr && link.bus_addr == OFS_FLAG;
    assign flag_rd = link.bus_rd && link.bus_addr == OFS_FLAG;
    assign lvl = irqcfg_q[IRQCFG_LVL_LSB +: LVL_W];
    assign vba = irqcfg_q[IRQCFG_VBA_LSB +: 4];
    assign adj = irqcfg_q[IRQCFG_ADJ_LSB +: 4];
    assign pm = flag_q & word_to_src(mask_q); // RULE_01 RULE_04
    assign any = |pm; // RULE_19
    // a zero only clears a flag that was read set and saw no event since
    assign clr = flag_wr ? (src_sel & ~word_to_src(link.bus_wdata) & armed_q & ~event_i)
        : '0; // RULE_02 RULE_03

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            modcfg_q <= MODCFG_RST;
            irqcfg_q <= IRQCFG_RST; // RULE_15
            mask_q <= MASK_RST; // RULE_05
        end else if (link.bus_wr) begin
            case (link.bus_addr)
                OFS_MODCFG: modcfg_q <= (modcfg_q & ~bmask) | (link.bus_wdata & bmask);
                OFS_IRQCFG: irqcfg_q <= (irqcfg_q & ~bmask) | (link.bus_wdata & bmask);
                OFS_MASK: mask_q <= (mask_q & ~bmask) | (link.bus_wdata & bmask); // RULE_05
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            flag_q <= FLAG_RST; // RULE_17
            armed_q <= '0;
        end else begin
            // a bus write can only clear; events set and win over a clear
            flag_q <= (flag_q & ~clr) | event_i; // RULE_17 RULE_03
            armed_q <= (armed_q & ~event_i & ~(flag_wr ? src_sel : '0))
                | (flag_rd ? (flag_q & src_sel) : '0); // RULE_02 RULE_03
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            rdata_q <= '0;
        end else if (link.bus_rd) begin
            case (link.bus_addr)
                OFS_MODCFG: rdata_q <= modcfg_q;
                OFS_IRQCFG: rdata_q <= irqcfg_q;
                OFS_MASK: rdata_q <= mask_q;
                default: rdata_q <= src_to_word(flag_q);
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            irq_q <= '0;
            pending_o <= 1'b0;
        end else begin
            pending_o <= any;
            for (int i = 1; i <= 7; i++) begin
                irq_q[i] <= any && lvl == 3'(i); // RULE_06 RULE_16
            end
        end
    end

    assign start = link.iack && !iack_prev_q;
    assign join_arb = lvl != 3'h0 && link.ack_level == lvl && any; // RULE_08

    arb_serial #(.W(ARB_W)) arb_serial_i (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .start_i(start),
        .join_i(join_arb),
        .id_i(modcfg_q[MODCFG_ARB_LSB +: ARB_W]),
        .bus_i(link.arb_bus),
        .bit_o(arb_bit),
        .won_o(won)
    );

    // the vector is frozen at acknowledge start so flag traffic cannot disturb it
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            iack_prev_q <= 1'b0;
            vec_q <= '0;
            vec_oe_q <= 1'b0;
        end else begin
            iack_prev_q <= link.iack;
            if (start) begin
                vec_q <= {vba, pick_code(pm, adj)}; // RULE_10 RULE_11 RULE_19
            end
            if (!link.iack) begin
                vec_oe_q <= 1'b0;
            end else if (won) begin
                vec_oe_q <= 1'b1; // RULE_10
            end
        end
    end

    assign link.bus_rdata = rdata_q;
    assign link.irq_req = irq_q;
    assign link.arb_dev = arb_bit;
    assign link.vec = vec_q;
    assign link.vec_oe = vec_oe_q;
endmodule

// File: rtl/timer_irq_cpu.sv
// cpu end: register access to the timer and interrupt acknowledge with priority mask
// assumes software drives the plain register port on the same clock
`timescale 1ns/100ps
module timer_irq_cpu (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // intermodule bus side
    timer_irq_if.cpu_mp link,
    // software port
    input wire logic [2:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    output logic irq_o
);
    import tim_irq_pkg::*;

    typedef enum logic [1:0] {H_IDLE, H_RDWAIT, H_ACK} hstate_e;

    hstate_e st_q;
    logic [1:0] baddr_q;
    logic [15:0] bdata_q;
    logic [1:0] be_q;
    logic go_wr_q;
    logic go_rd_q;
    logic bus_wr_q;
    logic bus_rd_q;
    logic iack_q;
    logic [2:0] ack_lvl_q;
    logic [2:0] ipm_q;
    logic auto_q;
    logic [3:0] cnt_q;
    logic [7:0] vec_last_q;
    logic [NUM_ST-1:0] stat_q;
    logic [NUM_ST-1:0] imask_q;
    logic [NUM_ST-1:0] ev;
    logic [2:0] top;

    always_comb begin
        top = 3'h0;
        for (int i = 1; i <= 7; i++) begin
            if (link.irq_req[i]) begin
                top = 3'(i);
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            st_q <= H_IDLE;
            baddr_q <= '0;
            bdata_q <= '0;
            be_q <= '0;
            go_wr_q <= 1'b0;
            go_rd_q <= 1'b0;
            bus_wr_q <= 1'b0;
            bus_rd_q <= 1'b0;
            iack_q <= 1'b0;
            ack_lvl_q <= '0;
            ipm_q <= '0;
            auto_q <= 1'b0;
            cnt_q <= '0;
            vec_last_q <= '0;
            ev <= '0;
        end else begin
            ev <= '0;
            bus_wr_q <= 1'b0;
            bus_rd_q <= 1'b0;
            if (wr_i) begin
                case (addr_i)
                    HOFS_ADDR: baddr_q <= wdata_i[1:0];
                    HOFS_DATA: bdata_q <= wdata_i;
                    HOFS_CMD: begin
                        go_wr_q <= go_wr_q | wdata_i[CMD_WR];
                        go_rd_q <= go_rd_q | wdata_i[CMD_RD];
                        be_q <= wdata_i[CMD_BE_LSB +: 2];
                    end
                    HOFS_IPM: begin
                        ipm_q <= wdata_i[2:0];
                        auto_q <= wdata_i[IPM_AUTO];
                    end
                    default: ;
                endcase
            end
            case (st_q)
                H_IDLE: begin
                    // acknowledge only a level above the current priority mask
                    if (auto_q && top > ipm_q) begin
                        st_q <= H_ACK;
                        iack_q <= 1'b1;
                        ack_lvl_q <= top; // RULE_07
                        ipm_q <= top; // RULE_07
                        cnt_q <= '0;
                    end else if (go_wr_q) begin
                        go_wr_q <= 1'b0;
                        bus_wr_q <= 1'b1;
                        ev[ST_BUS] <= 1'b1;
                    end else if (go_rd_q) begin
                        go_rd_q <= 1'b0;
                        bus_rd_q <= 1'b1;
                        st_q <= H_RDWAIT;
                    end
                end
                H_RDWAIT: begin
                    // read data stand one cycle after the strobe, so let the strobe cycle pass
                    if (!bus_rd_q) begin
                        st_q <= H_IDLE;
                        bdata_q <= link.bus_rdata;
                        ev[ST_BUS] <= 1'b1;
                    end
                end
                H_ACK: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == ACK_SAMPLE) begin
                        st_q <= H_IDLE;
                        iack_q <= 1'b0;
                        vec_last_q <= link.vec_bus;
                        ev[ST_ACK] <= link.vec_oe;
                        ev[ST_SPUR] <= !link.vec_oe;
                    end
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end

    // sticky status: an event in the cycle of a write-one clear still sets its bit
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            stat_q <= '0;
            imask_q <= '0;
            irq_o <= 1'b0;
        end else begin
            if (wr_i && addr_i == HOFS_IMASK) begin
                imask_q <= wdata_i[NUM_ST-1:0];
            end
            stat_q <= (stat_q & ~((wr_i && addr_i == HOFS_STAT) ? wdata_i[NUM_ST-1:0] : '0))
                | ev;
            irq_o <= |(stat_q & imask_q);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            case (addr_i)
                HOFS_ADDR: rdata_o <= {14'h0000, baddr_q};
                HOFS_DATA: rdata_o <= bdata_q;
                HOFS_CMD: rdata_o <= {10'h000, be_q, 2'h0, go_rd_q, go_wr_q};
                HOFS_IPM: rdata_o <= {12'h000, auto_q, ipm_q};
                HOFS_VEC: rdata_o <= {8'h00, vec_last_q};
                HOFS_STAT: rdata_o <= {13'h0000, stat_q};
                HOFS_IMASK: rdata_o <= {13'h0000, imask_q};
                default: rdata_o <= {13'h0000, st_q, 1'b0};
            endcase
        end
    end

    assign link.bus_addr = baddr_q;
    assign link.bus_wdata = bdata_q;
    assign link.bus_be = be_q;
    assign link.bus_wr = bus_wr_q;
    assign link.bus_rd = bus_rd_q;
    assign link.iack = iack_q;
    assign link.ack_level = ack_lvl_q;
endmodule

// File: testbench/timer_irq_properties.sv
// checker for the link between the timer interrupt device end and the cpu end
// assumes one clock domain; it sees the interface signals only
`timescale 1ns/100ps
module timer_irq_properties (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // link signals
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [15:0] bus_rdata,
    input wire logic [7:1] irq_req,
    input wire logic iack,
    input wire logic [2:0] ack_level,
    input wire logic arb_dev,
    input wire logic [7:0] vec,
    input wire logic vec_oe
);
    logic lvl_hit;

    // level zero shifts the single one out of range, so it never counts as a hit
    assign lvl_hit = |(irq_req & (7'h01 << (ack_level - 3'h1)));

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);

    one_line_a: assert property ($onehot0(irq_req))
        else $error("more than one request line high");
    ack_len_a: assert property ($rose(iack) |=> iack[*6] ##1 !iack)
        else $error("acknowledge not seven cycles long");
    ack_level_a: assert property ($rose(iack) |-> lvl_hit)
        else $error("acknowledge at a level nobody requests");
    arb_join_a: assert property (arb_dev |-> iack && lvl_hit)
        else $error("arbitration bit outside a matching acknowledge");
    vec_drive_a: assert property (
        $rose(vec_oe) |-> iack && $past(iack, 6) && !$past(iack, 7))
        else $error("vector driven at the wrong cycle");
    vec_off_a: assert property ($fell(iack) |=> !vec_oe)
        else $error("vector still driven after acknowledge");
    vec_hold_a: assert property (vec_oe && $past(vec_oe) |-> $stable(vec))
        else $error("vector changed while driven");
    vec_latch_a: assert property (!$stable(vec) |-> $past(iack) && !$past(iack, 2))
        else $error("vector changed outside acknowledge start");
    req_hold_a: assert property ($fell(|irq_req) |-> $past(bus_wr, 2))
        else $error("request dropped without a clearing write");
    rdata_hold_a: assert property (!$stable(bus_rdata) |-> $past(bus_rd))
        else $error("read data changed without a read");

    cover property ($rose(vec_oe));
    cover property ($fell(|irq_req));
    cover property (arb_dev);
    cover property ($rose(iack));
endmodule

// File: testbench/timer_interrupt_logic_bench.sv
// self-checking bench for the timer interrupt device end facing the cpu end
// assumes a 10 MHz clock; software is played by the register port tasks
`timescale 1ns/100ps
module timer_interrupt_logic_bench;
    import tim_irq_pkg::*;
    typedef struct {
        logic [15:0] cfg;
        logic [10:0] ev;
        logic [3:0] code;
    } row_s;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [10:0] event_i = 11'h000;
    logic [15:0] rdata_o;
    logic irq_o;
    logic pending_o;
    logic [15:0] d;
    int num_errors = 0;
    int checks = 0;
    // level 5, base nibble 4; last rows lift source 9 or 11 by the adjust field
    row_s rows [16] = '{
        '{16'h0054, 11'h001, 4'h1}, '{16'h0054, 11'h002, 4'h2}, '{16'h0054, 11'h004, 4'h3},
        '{16'h0054, 11'h008, 4'h4}, '{16'h0054, 11'h010, 4'h5}, '{16'h0054, 11'h020, 4'h6},
        '{16'h0054, 11'h040, 4'h7}, '{16'h0054, 11'h080, 4'h8}, '{16'h0054, 11'h100, 4'h9},
        '{16'h0054, 11'h200, 4'hA}, '{16'h0054, 11'h400, 4'hB}, '{16'h0054, 11'h600, 4'hA},
        '{16'h0054, 11'h618, 4'h4}, '{16'h0954, 11'h101, 4'h0}, '{16'h0954, 11'h001, 4'h1},
        '{16'h0B54, 11'h7FF, 4'h0}};

    timer_irq_if timer_irq_if_i ();
    timer_irq_dev timer_irq_dev_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .link(timer_irq_if_i), .event_i(event_i), .pending_o(pending_o));
    timer_irq_cpu timer_irq_cpu_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .link(timer_irq_if_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
    timer_irq_properties timer_irq_properties_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .bus_wr(timer_irq_if_i.bus_wr), .bus_rd(timer_irq_if_i.bus_rd),
        .bus_rdata(timer_irq_if_i.bus_rdata), .irq_req(timer_irq_if_i.irq_req),
        .iack(timer_irq_if_i.iack), .ack_level(timer_irq_if_i.ack_level),
        .arb_dev(timer_irq_if_i.arb_dev), .vec(timer_irq_if_i.vec),
        .vec_oe(timer_irq_if_i.vec_oe));

    always #50 sys_clk_i = ~sys_clk_i;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic sw(input logic [2:0] a, input logic [15:0] v);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic sr(input logic [2:0] a, output logic [15:0] v);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask

    // polls a status bit under a bound, then clears it by writing one
    task automatic wait_st(input int b);
        logic [15:0] s;
        s = 16'h0000;
        for (int n = 0; n < 40 && s[b] !== 1'b1; n++) sr(HOFS_STAT, s);
        if (s[b] !== 1'b1) begin
            num_errors++;
            $display("unexpected at %0t: completion never seen", $time);
            complete_run();
        end
        sw(HOFS_STAT, 16'h0001 << b);
    endtask

    task automatic dwr(input logic [1:0] a, input logic [15:0] v, input logic [1:0] be);
        sw(HOFS_ADDR, {14'h0000, a});
        sw(HOFS_DATA, v);
        sw(HOFS_CMD, {10'h000, be, 4'h1});
        wait_st(ST_BUS);
    endtask

    task automatic drd(input logic [1:0] a, output logic [15:0] v);
        sw(HOFS_ADDR, {14'h0000, a});
        sw(HOFS_CMD, 16'h0032);
        wait_st(ST_BUS);
        sr(HOFS_DATA, v);
    endtask

    task automatic ev(input logic [10:0] e);
        @(posedge sys_clk_i);
        event_i <= e;
        @(posedge sys_clk_i);
        event_i <= 11'h000;
    endtask

    // source k+1 sits at word bit 15-k
    function automatic logic [15:0] flags_of(input logic [10:0] e);
        logic [15:0] f;
        f = 16'h0000;
        for (int k = 0; k < 11; k++) f[15-k] = e[k];
        return f;
    endfunction

    initial begin
        repeat (2) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        dwr(OFS_MODCFG, 16'h0005, 2'h3);
        dwr(OFS_MASK, 16'hFFE0, 2'h3);
        foreach (rows[i]) begin
            dwr(OFS_IRQCFG, rows[i].cfg, 2'h3);
            ev(rows[i].ev);
            settle(3);
            check(pending_o, 1'b1);
            check(timer_irq_if_i.irq_req, 7'h10);
            sw(HOFS_IPM, 16'h0008);
            // a new top source arriving mid-acknowledge must not move the vector
            settle(4);
            ev(11'h001);
            wait_st(ST_ACK);
            sr(HOFS_VEC, d);
            check({8'h00, d[7:0]}, {12'h004, rows[i].code});
            check(timer_irq_if_i.irq_req, 7'h10);
            drd(OFS_FLAG, d);
            check(d, flags_of(rows[i].ev) | 16'h8000);
            dwr(OFS_FLAG, 16'h0000, 2'h3);
            settle(3);
            check(timer_irq_if_i.irq_req, 7'h00);
            $display("row %0d done", i);
        end
        sw(HOFS_IPM, 16'h0000);
        ev(11'h008);
        dwr(OFS_FLAG, 16'h0000, 2'h3);
        drd(OFS_FLAG, d);
        check(d, 16'h1000);
        dwr(OFS_FLAG, 16'hFFFF, 2'h3);
        drd(OFS_FLAG, d);
        check(d, 16'h1000);
        ev(11'h008);
        dwr(OFS_FLAG, 16'h0000, 2'h3);
        drd(OFS_FLAG, d);
        check(d, 16'h1000);
        dwr(OFS_FLAG, 16'h0000, 2'h3);
        drd(OFS_FLAG, d);
        check(d, 16'h0000);
        dwr(OFS_FLAG, 16'hFFFF, 2'h3);
        drd(OFS_FLAG, d);
        check(d, 16'h0000);
        $display("flag clearing done");
        dwr(OFS_MASK, 16'h7FE0, 2'h3);
        ev(11'h001);
        settle(3);
        check(pending_o, 1'b0);
        dwr(OFS_MASK, 16'hABCD, 2'h1);
        dwr(OFS_MASK, 16'hFFFF, 2'h2);
        drd(OFS_MASK, d);
        check(d, 16'hFFCD);
        check(pending_o, 1'b1);
        dwr(OFS_IRQCFG, 16'h0004, 2'h3);
        settle(3);
        check(timer_irq_if_i.irq_req, 7'h00);
        dwr(OFS_IRQCFG, 16'h0074, 2'h3);
        settle(3);
        check(timer_irq_if_i.irq_req, 7'h40);
        $display("mask and level done");
        sw(HOFS_CMD, 16'h0032);
        settle(6);
        check(irq_o, 1'b0);
        sw(HOFS_IMASK, 16'h0001);
        settle(2);
        check(irq_o, 1'b1);
        sw(HOFS_STAT, 16'h0001);
        settle(2);
        check(irq_o, 1'b0);
        $display("cpu interrupt done");
        @(posedge sys_clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        settle(1);
        check(pending_o, 1'b0);
        check(timer_irq_if_i.irq_req, 7'h00);
        for (int a = 0; a < 4; a++) begin
            drd(a[1:0], d);
            check(d, 16'h0000);
        end
        $display("reset done");
        complete_run();
    end
endmodule
